// >>> hdl/gqd_dispatcher.sv
// Group dispatcher top: weighted round-robin over work queues, traffic class tagging,
// per-engine outstanding limit, AXI4-Lite register slave, 16-entry output FIFO.
// Assumes queue heads and engine signals are on clk; engines take output in order.
`default_nettype none
module gqd_dispatcher #(
  parameter int NQ = gqd_pkg::NUM_QUEUES,
  parameter int NE = gqd_pkg::NUM_ENGINES,
  parameter int DW = 32,
  parameter int DEPTH = gqd_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  // Work queue heads
  input wire logic [NQ-1:0] queueValid,
  input wire logic [NQ*DW-1:0] queueData,
  input wire logic [NQ*2-1:0] queueTcSel,
  output logic [NQ-1:0] queuePop,
  // Engine side
  output logic dispValid,
  input wire logic dispReady,
  output logic [DW-1:0] dispData,
  output logic [$clog2(NQ)-1:0] dispQueue,
  output logic [$clog2(NE)-1:0] dispEngine,
  output logic [gqd_pkg::TC_WIDTH-1:0] dispSrcTc,
  output logic [gqd_pkg::TC_WIDTH-1:0] dispDstTc,
  input wire logic [NE-1:0] engineDone,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int QW = $clog2(NQ);
  localparam int EW = $clog2(NE);
  localparam int TW = gqd_pkg::TC_WIDTH;
  localparam int CW = gqd_pkg::CNT_WIDTH;
  localparam int PW = gqd_pkg::PRIO_WIDTH;
  localparam int FW = DW + QW + EW + 2 * TW;

  // Legal priority: only the low four bits are kept and a zero is raised to 1, giving 1..15
  function automatic logic [PW-1:0] clampPrio(input logic [PW-1:0] v);
    clampPrio = (v < gqd_pkg::PRIO_MIN) ? gqd_pkg::PRIO_MIN : v;
  endfunction : clampPrio

  // Byte-lane merge used by the control and traffic class registers
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      mergeBytes[b*8 +: 8] = st[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : mergeBytes

  // Configuration registers
  logic enable_q;
  logic [NQ-1:0] queueEn_q;
  logic [TW-1:0] tcA_q;
  logic [TW-1:0] tcB_q;
  logic vcPresent_q;
  logic [CW-1:0] limit_q;
  logic [PW-1:0] prio_q [NQ];
  logic [31:0] dispCount_q;

  // Arbiter state
  logic [CW-1:0] credit_q [NQ];
  logic [QW-1:0] turn_q;
  logic [CW-1:0] outst_q [NE];
  logic [EW-1:0] engPtr_q;

  // Pin inputs from the queue side arrive on clk, so no synchroniser is needed
  logic [NQ-1:0] hasCredit;
  logic [NQ-1:0] eligible;
  logic [NQ-1:0] pendZero;
  logic [NQ-1:0] zeroVec;
  logic [NE-1:0] engOpen;
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      hasCredit[i] = queueEn_q[i] && queueValid[i] && (credit_q[i] != '0);
      pendZero[i] = queueEn_q[i] && queueValid[i] && (credit_q[i] == '0);
      zeroVec[i] = (credit_q[i] == '0);
    end
    for (int e = 0; e < NE; e++) begin
      engOpen[e] = (outst_q[e] < limit_q);
    end
  end
  wire anyPending = |(queueEn_q & queueValid);
  // Reload and dispatch share one cycle, so a lone low-priority queue still runs at full rate
  wire reloadAll = enable_q && anyPending && (hasCredit == '0);
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      eligible[i] = reloadAll ? (queueEn_q[i] && queueValid[i] && (prio_q[i] != '0)) : hasCredit[i];
    end
  end

  // Next eligible queue at or after the turn pointer in one cycle, so empty ones cost nothing
  logic found;
  logic [QW-1:0] pick;
  always_comb begin
    found = 1'b0;
    pick = '0;
    for (int k = 0; k < NQ; k++) begin
      if (!found && eligible[QW'((32'(turn_q) + k) % NQ)]) begin
        found = 1'b1;
        pick = QW'((32'(turn_q) + k) % NQ);
      end
    end
  end

  // Next engine with room, round-robin among engines
  logic engFound;
  logic [EW-1:0] engPick;
  always_comb begin
    engFound = 1'b0;
    engPick = '0;
    for (int k = 0; k < NE; k++) begin
      if (!engFound && engOpen[EW'((32'(engPtr_q) + k) % NE)]) begin
        engFound = 1'b1;
        engPick = EW'((32'(engPtr_q) + k) % NE);
      end
    end
  end

  gqd_fifo_if #(.WIDTH(FW)) toFifo ();
  // Gated by clkEn so a frozen cycle never pops a queue it cannot record
  wire fire = clkEn && enable_q && found && engFound && toFifo.ready;
  wire [NQ-1:0] pickOneHot = NQ'(1) << pick;
  wire [DW-1:0] pickData = queueData[pick*DW +: DW];
  wire [1:0] pickSel = queueTcSel[pick*2 +: 2];
  wire [TW-1:0] srcTc = vcPresent_q ? (pickSel[0] ? tcB_q : tcA_q) : '0;
  wire [TW-1:0] dstTc = vcPresent_q ? (pickSel[1] ? tcB_q : tcA_q) : '0;
  assign queuePop = fire ? pickOneHot : '0;
  assign toFifo.valid = fire;
  assign toFifo.data = {pickData, pick, engPick, srcTc, dstTc};

  always_ff @(posedge clk) begin
    if (reset) begin
      turn_q <= '0;
      engPtr_q <= '0;
      for (int i = 0; i < NQ; i++) credit_q[i] <= gqd_pkg::PRIO_RESET;
    end else if (clkEn) begin
      for (int i = 0; i < NQ; i++) begin
        if (reloadAll) begin
          credit_q[i] <= (fire && pick == QW'(i)) ? prio_q[i] - 1'b1 : prio_q[i];
        end else if (fire && pick == QW'(i)) begin
          credit_q[i] <= credit_q[i] - 1'b1;
        end
      end
      if (fire) begin
        turn_q <= (pick == QW'(NQ - 1)) ? '0 : pick + 1'b1;
        engPtr_q <= (engPick == EW'(NE - 1)) ? '0 : engPick + 1'b1;
      end
    end
  end

  // Outstanding count: dispatch counts in, completion counts out, both may hit at once
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int e = 0; e < NE; e++) outst_q[e] <= '0;
    end else if (clkEn) begin
      for (int e = 0; e < NE; e++) begin
        outst_q[e] <= outst_q[e] + CW'(fire && engPick == EW'(e)) - CW'(engineDone[e] && outst_q[e] != '0);
      end
    end
  end

  logic fifoOutValid;
  logic [FW-1:0] fifoOutData;
  // Output register stage; FIFO drains only when the stage is free or being taken
  wire stageFree = !dispValid || dispReady;
  gqd_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) outFifo (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .inPort(toFifo),
    .outValid(fifoOutValid),
    .outReady(stageFree),
    .outData(fifoOutData)
  );
  always_ff @(posedge clk) begin
    if (reset) begin
      dispValid <= 1'b0;
      dispData <= '0;
      dispQueue <= '0;
      dispEngine <= '0;
      dispSrcTc <= '0;
      dispDstTc <= '0;
    end else if (clkEn && stageFree) begin
      dispValid <= fifoOutValid;
      {dispData, dispQueue, dispEngine, dispSrcTc, dispDstTc} <= fifoOutData;
    end
  end

  // AXI4-Lite write path: address and data taken in either order, response after both
  logic awHave_q;
  logic wHave_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire [7:0] wa = awAddr_q;
  wire wIsCtrl = (wa == gqd_pkg::CTRL_OFFSET);
  wire wIsTc = (wa == gqd_pkg::TCLASS_OFFSET);
  wire wIsLim = (wa == gqd_pkg::LIMIT_OFFSET);
  wire wIsCnt = (wa == gqd_pkg::DISPCNT_OFFSET);
  wire [5:0] wPrioIdx = 6'((wa - gqd_pkg::PRIO_OFFSET) >> 2);
  wire wIsPrio = (wa >= gqd_pkg::PRIO_OFFSET) && (wPrioIdx < 6'(NQ)) && (wa[1:0] == 2'h0);
  wire wMapped = wIsCtrl || wIsTc || wIsLim || wIsCnt || wIsPrio || (wa == gqd_pkg::STATUS_OFFSET);
  wire [31:0] ctrlWord = {16'h0000, 8'(queueEn_q), 7'h00, enable_q};
  wire [31:0] tcWord = {15'h0000, vcPresent_q, 5'h00, tcB_q, 5'h00, tcA_q};
  wire [31:0] ctrlNew = mergeBytes(ctrlWord, wData_q, wStrb_q);
  wire [31:0] tcNew = mergeBytes(tcWord, wData_q, wStrb_q);
  // No new write is taken while the previous response is still pending
  assign s_axi_awready = clkEn && !awHave_q && !s_axi_bvalid;
  assign s_axi_wready = clkEn && !wHave_q && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gqd_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (awTake) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? gqd_pkg::RESP_OKAY : gqd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage written by software; traffic classes stored as given
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_q <= 1'b0;
      queueEn_q <= '0;
      tcA_q <= '0;
      tcB_q <= '0;
      vcPresent_q <= 1'b0;
      limit_q <= gqd_pkg::LIMIT_RESET;
      for (int i = 0; i < NQ; i++) prio_q[i] <= gqd_pkg::PRIO_RESET;
    end else if (clkEn && doWrite) begin
      if (wIsCtrl) begin
        enable_q <= ctrlNew[gqd_pkg::CTRL_ENABLE_POS];
        queueEn_q <= ctrlNew[gqd_pkg::CTRL_QEN_POS +: NQ];
      end
      if (wIsTc) begin
        tcA_q <= tcNew[gqd_pkg::TCLASS_A_POS +: TW];
        tcB_q <= tcNew[gqd_pkg::TCLASS_B_POS +: TW];
        vcPresent_q <= tcNew[gqd_pkg::TCLASS_VC_POS];
      end
      if (wIsLim && wStrb_q[0]) limit_q <= wData_q[CW-1:0];
      if (wIsPrio && wStrb_q[0]) prio_q[wPrioIdx[QW-1:0]] <= clampPrio(wData_q[PW-1:0]);
    end
  end

  // Dispatch counter: a software clear in the same cycle as a dispatch leaves the count at one
  always_ff @(posedge clk) begin
    if (reset) begin
      dispCount_q <= '0;
    end else if (clkEn) begin
      if (fire) dispCount_q <= (doWrite && wIsCnt) ? 32'h00000001 : dispCount_q + 32'h00000001;
      else if (doWrite && wIsCnt) dispCount_q <= '0;
    end
  end

  // AXI4-Lite read path, one read at a time
  wire [7:0] ra = s_axi_araddr;
  wire [5:0] rPrioIdx = 6'((ra - gqd_pkg::PRIO_OFFSET) >> 2);
  wire rIsPrio = (ra >= gqd_pkg::PRIO_OFFSET) && (rPrioIdx < 6'(NQ)) && (ra[1:0] == 2'h0);
  logic [NE-1:0] engStall;
  always_comb begin
    for (int e = 0; e < NE; e++) engStall[e] = !engOpen[e];
  end
  wire [31:0] statusWord = {8'h00, 8'(engStall), 8'(zeroVec), 8'(pendZero | eligible)};
  wire rMapped = rIsPrio || (ra == gqd_pkg::CTRL_OFFSET) || (ra == gqd_pkg::TCLASS_OFFSET) ||
                 (ra == gqd_pkg::LIMIT_OFFSET) || (ra == gqd_pkg::STATUS_OFFSET) || (ra == gqd_pkg::DISPCNT_OFFSET);
  wire [31:0] rWord = (ra == gqd_pkg::CTRL_OFFSET) ? ctrlWord :
                      (ra == gqd_pkg::TCLASS_OFFSET) ? tcWord :
                      (ra == gqd_pkg::LIMIT_OFFSET) ? 32'(limit_q) :
                      (ra == gqd_pkg::STATUS_OFFSET) ? statusWord :
                      (ra == gqd_pkg::DISPCNT_OFFSET) ? dispCount_q :
                      rIsPrio ? 32'(prio_q[rPrioIdx[QW-1:0]]) : 32'h00000000;
  assign s_axi_arready = clkEn && !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= gqd_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rWord;
        s_axi_rresp <= rMapped ? gqd_pkg::RESP_OKAY : gqd_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : gqd_dispatcher
`default_nettype wire

// >>> hdl/gqd_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and honest full/empty.
// Assumes one clock; writer sees ready low when full.
`default_nettype none
module gqd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  gqd_fifo_if.sink inPort,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push = inPort.valid && inPort.ready;
  wire pop = outValid && outReady;
  assign inPort.ready = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else if (clkEn) begin
      if (push) begin
        mem_q[wrPtr_q] <= inPort.data;
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : gqd_fifo
`default_nettype wire

// >>> hdl/gqd_fifo_if.sv
// Stream carrier between the dispatcher and its output FIFO.
// Assumes both ends on the same clock.
`default_nettype none
interface gqd_fifo_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : gqd_fifo_if
`default_nettype wire

// >>> hdl/gqd_pkg.sv
// Package for the group queue dispatcher: register map, field layout, reset values.
// Assumes one clock, synchronous active-high reset, AXI4-Lite software access.
// Overview of operation
// - Each work queue holds priority 1 to 15
// - Any priority mix accepted, duplicates allowed
// - Per-queue credit loaded from priority, decremented
// - Round-robin; dispatch if pending and credit nonzero
// - Zero credit blocks queue until reload
// - Reload all when all pending queues zero
// - Newly filled queue dispatches on next turn
// - Empty queues skipped at no cost
// - Full engine rate even for low priority
// - Tag memory transactions with traffic class
// - Group holds two independent traffic class fields
// - Per-address selector picks class A or B
// - Stall engine at outstanding limit until completion
`default_nettype none
package gqd_pkg;
  localparam int NUM_QUEUES = 4;
  localparam int NUM_ENGINES = 2;
  localparam int PRIO_WIDTH = 4;
  localparam int TC_WIDTH = 3;
  localparam int CNT_WIDTH = 4;
  localparam logic [PRIO_WIDTH-1:0] PRIO_MIN = 4'h1;
  localparam logic [PRIO_WIDTH-1:0] PRIO_MAX = 4'hf;
  localparam logic [PRIO_WIDTH-1:0] PRIO_RESET = 4'h1;
  localparam logic [CNT_WIDTH-1:0] LIMIT_RESET = 4'h4;
  localparam int FIFO_DEPTH = 16;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] TCLASS_OFFSET = 8'h04;
  localparam logic [7:0] LIMIT_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] DISPCNT_OFFSET = 8'h10;
  localparam logic [7:0] PRIO_OFFSET = 8'h20;
  // Field positions
  localparam int CTRL_ENABLE_POS = 0;
  localparam int CTRL_QEN_POS = 8;
  localparam int TCLASS_A_POS = 0;
  localparam int TCLASS_B_POS = 8;
  localparam int TCLASS_VC_POS = 16;
  localparam int STATUS_PEND_POS = 0;
  localparam int STATUS_ZERO_POS = 8;
  localparam int STATUS_STALL_POS = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gqd_pkg
`default_nettype wire

// >>> testbench/gqd_dispatcher_assertions.sv
// Port-level checker for the group dispatcher: pop, output-stage and register-bus handshakes.
// Assumes clkEn is held high by the surrounding bench; bound onto every dispatcher.
`default_nettype none
module gqd_dispatcher_assertions #(parameter int NQ = 4) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [NQ-1:0] queueValid,
  input wire logic [NQ-1:0] queuePop,
  input wire logic dispValid,
  input wire logic dispReady,
  input wire logic [31:0] dispData,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_one_pop;
    $onehot0(queuePop);
  endproperty
  a_one_pop: assert property (p_one_pop) else $error("several queues popped at once");
  property p_pop_pending;
    (queuePop & ~queueValid) == '0;
  endproperty
  a_pop_pending: assert property (p_pop_pending) else $error("pop from an empty queue");
  property p_hold;
    dispValid && !dispReady |=> dispValid && $stable(dispData);
  endproperty
  a_hold: assert property (p_hold) else $error("descriptor dropped before taken");
  // A pop into an idle output stage must reach the output within two cycles
  property p_latency;
    (queuePop != '0) && !dispValid |-> ##[1:2] dispValid;
  endproperty
  a_latency: assert property (p_latency) else $error("popped descriptor late at output");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response withdrawn");
  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("write taken while response pending");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data changed before taken");
  c_pop_idle: cover property ((queuePop != '0) && !dispValid);
  c_stall: cover property ((dispValid && !dispReady) [*3]);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : gqd_dispatcher_assertions
bind gqd_dispatcher gqd_dispatcher_assertions #(.NQ(NQ)) chk (.clk, .reset, .queueValid, .queuePop,
  .dispValid, .dispReady, .dispData, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// >>> testbench/gqd_engine_model.sv
// Behavioural engines of one group: take descriptors, complete them after a delay.
// Assumes mode 0 prompt, 1 slow with random stalls, 2 stalled; maxOut cleared by reset.
`default_nettype none
module gqd_engine_model #(parameter int NE = 2) (
  input wire logic clk,
  input wire logic reset,
  input wire logic dispValid,
  input wire logic [$clog2(NE)-1:0] dispEngine,
  input wire logic [1:0] mode,
  output logic dispReady,
  output logic [NE-1:0] engineDone,
  output int maxOut
);
  timeunit 1ns;
  timeprecision 1ps;
  int outCnt[NE];
  int timer[NE];
  always @(posedge clk) begin
    for (int e = 0; e < NE; e++) begin
      engineDone[e] <= 1'b0;
      if (reset) begin
        outCnt[e] = 0;
        timer[e] = 0;
        maxOut = 0;
      end else begin
        if (outCnt[e] > 0) timer[e]++;
        // Completes only what it holds, so the limit is never freed early
        if (outCnt[e] > 0 && timer[e] >= (mode == 2'h0 ? 1 : 7)) begin
          engineDone[e] <= 1'b1;
          outCnt[e]--;
          timer[e] = 0;
        end
        if (dispValid && dispReady && dispEngine == e) outCnt[e]++;
        if (outCnt[e] > maxOut) maxOut = outCnt[e];
      end
    end
    dispReady <= !reset && (mode == 2'h0 || (mode == 2'h1 && $urandom_range(2) != 0));
  end
endmodule : gqd_engine_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the group dispatcher: registers, weighted dispatch, limits, buffering.
// Assumes the engine model on the engine side; work queue heads are modelled here.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NQ = gqd_pkg::NUM_QUEUES;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [NQ-1:0] queueValid, queuePop;
  logic [NQ*32-1:0] queueData;
  logic [NQ*2-1:0] queueTcSel = '0;
  logic dispValid, dispReady;
  logic [31:0] dispData;
  logic [1:0] dispQueue;
  logic [0:0] dispEngine;
  logic [2:0] dispSrcTc, dispDstTc;
  logic [1:0] engineDone, mode = 2'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int maxOut, fails = 0, checked = 0;
  int cnt[NQ] = '{default: 0};
  int total[NQ] = '{default: 0};
  logic [31:0] base[NQ] = '{default: 0};
  logic [63:0] dispQ[$], rdQ[$], bQ[$];

  gqd_dispatcher dut (.clk, .reset, .clkEn(1'b1), .queueValid, .queueData, .queueTcSel, .queuePop, .dispValid,
    .dispReady, .dispData, .dispQueue, .dispEngine, .dispSrcTc, .dispDstTc, .engineDone, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  gqd_engine_model model (.clk, .reset, .dispValid, .dispEngine, .mode, .dispReady, .engineDone, .maxOut);

  always #2 clk = ~clk;
  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      queueValid[i] = cnt[i] < total[i];
      queueData[i*32+:32] = base[i] ^ 32'(cnt[i]);
    end
  end
  always @(posedge clk) begin
    for (int i = 0; i < NQ; i++) begin
      if (queuePop[i]) cnt[i] <= cnt[i] + 1;
    end
    if (dispValid && dispReady) check({24'h0, dispQueue, dispSrcTc, dispDstTc, dispData},
      dispQ.size() > 0 ? dispQ.pop_front() : '1);
    if (s_axi_rvalid && s_axi_rready) check({30'h0, s_axi_rresp, s_axi_rdata},
      rdQ.size() > 0 ? rdQ.pop_front() : '1);
    if (s_axi_bvalid && s_axi_bready) check({62'h0, s_axi_bresp}, bQ.size() > 0 ? bQ.pop_front() : '1);
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("Counts: %0d compared, %0d mismatched", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic guard(input int n);
    if (n >= 5000) begin
      fails++;
      $display("Wait ran out at %0t", $time);
      summarize();
    end
  endtask : guard
  task automatic doReset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask : doReset
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bQ.push_back({62'h0, r});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    guard(n);
    s_axi_bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rdQ.push_back({30'h0, r, d});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    guard(n);
    s_axi_rready <= 1'b0;
  endtask : axiRead

  // Builds the expected dispatch order from credits, then lets the engines drain it
  task automatic runTraffic(input logic vc, input logic [3:0] lim, input logic [1:0] md, input logic fill);
    int p, pick, n, sum, any, nd;
    int rem[NQ], cred[NQ], st[NQ], kk[NQ];
    logic [3:0] prio[NQ];
    logic [31:0] b[NQ];
    logic [2:0] tcA, tcB;
    logic [7:0] sel;
    logic [NQ-1:0] qen, zb;
    doReset();
    mode <= md;
    qen = fill ? 4'hf : 4'hd;
    tcA = 3'($urandom);
    tcB = 3'($urandom);
    sel = 8'($urandom);
    queueTcSel <= sel;
    for (int i = 0; i < NQ; i++) begin
      kk[i] = fill ? 40 : $urandom_range(10);
      rem[i] = kk[i];
      st[i] = cnt[i];
      cred[i] = 1;
      b[i] = $urandom;
      base[i] <= b[i];
      total[i] <= cnt[i] + kk[i];
      prio[i] = 4'($urandom_range(15, 1));
    end
    prio[NQ-1] = prio[NQ-2];
    for (int i = 0; i < NQ; i++) axiWrite(gqd_pkg::PRIO_OFFSET + 8'(4 * i), 32'(prio[i]), gqd_pkg::RESP_OKAY);
    axiWrite(gqd_pkg::TCLASS_OFFSET, {15'h0, vc, 5'h0, tcB, 5'h0, tcA}, gqd_pkg::RESP_OKAY);
    axiWrite(gqd_pkg::LIMIT_OFFSET, 32'(lim), gqd_pkg::RESP_OKAY);
    p = 0;
    nd = 0;
    for (int s = 0; s < 400; s++) begin
      pick = -1;
      any = 0;
      for (int j = 0; j < NQ; j++) begin
        n = (p + j) % NQ;
        if (pick < 0 && qen[n] && rem[n] > 0 && cred[n] > 0) pick = n;
        if (qen[j] && rem[j] > 0) any = 1;
      end
      if (any == 0) break;
      if (pick < 0) begin
        for (int j = 0; j < NQ; j++) cred[j] = prio[j];
      end else begin
        dispQ.push_back({24'h0, 2'(pick), vc && sel[2*pick] ? tcB : vc ? tcA : 3'h0,
          vc && sel[2*pick+1] ? tcB : vc ? tcA : 3'h0, b[pick] ^ 32'(st[pick] + kk[pick] - rem[pick])});
        cred[pick]--;
        rem[pick]--;
        nd++;
        p = (pick + 1) % NQ;
      end
    end
    axiWrite(gqd_pkg::CTRL_OFFSET, 32'({qen, 8'h01}), gqd_pkg::RESP_OKAY);
    if (fill) begin
      repeat (60) @(posedge clk);
      sum = 0;
      for (int i = 0; i < NQ; i++) sum += cnt[i] - st[i];
      check(64'(sum), 64'(gqd_pkg::FIFO_DEPTH + 1));
      mode <= 2'h0;
    end
    for (n = 0; n < 5000 && dispQ.size() > 0; n++) @(posedge clk);
    guard(n);
    repeat (20) @(posedge clk);
    check(64'(maxOut <= lim), 64'h1);
    axiRead(gqd_pkg::DISPCNT_OFFSET, 32'(nd), gqd_pkg::RESP_OKAY);
    axiWrite(gqd_pkg::DISPCNT_OFFSET, 32'h0, gqd_pkg::RESP_OKAY);
    axiRead(gqd_pkg::DISPCNT_OFFSET, 32'h0, gqd_pkg::RESP_OKAY);
    for (int j = 0; j < NQ; j++) zb[j] = (cred[j] == 0);
    axiRead(gqd_pkg::STATUS_OFFSET, {16'h0, 8'(zb), 8'h0}, gqd_pkg::RESP_OKAY);
    $display("Traffic test done: vc %0d limit %0d mode %0d", vc, lim, md);
  endtask : runTraffic

  initial begin
    void'($urandom(98));
    doReset();
    axiRead(gqd_pkg::CTRL_OFFSET, 32'h0, gqd_pkg::RESP_OKAY);
    axiRead(gqd_pkg::LIMIT_OFFSET, 32'(gqd_pkg::LIMIT_RESET), gqd_pkg::RESP_OKAY);
    for (int i = 0; i < NQ; i++) axiRead(gqd_pkg::PRIO_OFFSET + 8'(4 * i), 32'h1, gqd_pkg::RESP_OKAY);
    axiWrite(gqd_pkg::PRIO_OFFSET, 32'h0, gqd_pkg::RESP_OKAY);
    axiRead(gqd_pkg::PRIO_OFFSET, 32'h1, gqd_pkg::RESP_OKAY);
    axiWrite(gqd_pkg::PRIO_OFFSET + 8'h4, 32'hf, gqd_pkg::RESP_OKAY);
    axiRead(gqd_pkg::PRIO_OFFSET + 8'h4, 32'hf, gqd_pkg::RESP_OKAY);
    axiWrite(8'h40, 32'h5a, gqd_pkg::RESP_SLVERR);
    axiRead(8'h40, 32'h0, gqd_pkg::RESP_SLVERR);
    $display("Register test done");
    runTraffic(1'b1, 4'h4, 2'h0, 1'b0);
    runTraffic(1'b0, 4'h1, 2'h1, 1'b0);
    runTraffic(1'b1, 4'hf, 2'h2, 1'b1);
    summarize();
  end
endmodule : testbench
`default_nettype wire
